/* design/dfs_regs.vh */
// Purpose: Constants of the driver diagnostic status bank
// Assumes: 6-bit register index, 16-bit data
// Notes: Header only
`ifndef DFS_REGS_VH
`define DFS_REGS_VH
`define DFS_ADDR_W 6
`define DFS_DATA_W 16
`define DFS_OFS_ULD 6'h11
`define DFS_OFS_SUP 6'h12
`define DFS_OFS_CFG 6'h3F
`define DFS_ULD_LSB 6
`define DFS_ULD_MSB 9
`define DFS_BIT_UV 3
`define DFS_BIT_OV 2
`define DFS_BIT_TWM 3
`define DFS_BIT_ULDM 1
`define DFS_BIT_SWAP 0
`define DFS_CFG_MASK 16'h000B
`define DFS_RST_VAL 16'h0000
`define DFS_ULD_FILT_NS 2000
`define DFS_ULD_FILT_CYC 12'h1F4
`define DFS_CLK_NS 4
`endif

/* design/dfs_uld_filter.v */
// Purpose: Underload filter for one output switch
// Assumes: Inputs already synchronised
// Notes: Goes high and stays high while low current persists while on
`timescale 1ns/10ps
`default_nettype none
module dfs_uld_filter #(
  parameter CNT_W = 12,
  parameter [11:0] FILT_CYC = 12'h1F4
) (
  input wire clk_sys,
  input wire rst_n,
  input wire out_on,
  input wire low_cur,
  output reg detect_q
);
  reg [CNT_W-1:0] cnt_q;
  // ----------------------------------------
  // Filter counter
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= {CNT_W{1'b0}};
      detect_q <= 1'b0;
    end
    else if (out_on && low_cur)
    begin
      if (cnt_q >= FILT_CYC - 12'h001)
      begin
        detect_q <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        detect_q <= 1'b0;
      end
    end
    else
    begin
      cnt_q <= {CNT_W{1'b0}};
      detect_q <= 1'b0;
    end
  end
endmodule // dfs_uld_filter
`default_nettype wire

/* design/dfs_driver_fault_status_regs.v */
// Purpose: Diagnostic status and configuration bank of a half-bridge driver
// Assumes: Register port with read, read-and-clear and write strobes
// Notes: Fault inputs are asynchronous and pass three flip-flops
// Operation
// - Four underload flags sit in bits nine down to six.
// - Underload judged only while on, after the filter time.
// - Any underload flag raises the global underload indication.
// - Global underload mask hides global indication; per-output flags stay.
// - Undervoltage switches all outputs off and sets bit three.
// - Overvoltage switches all outputs off and sets bit two.
// - Latch select clear: outputs return when supply recovers.
// - Latch select set: outputs stay off until host clears flag.
// - Thermal warning mask hides the global thermal warning.
// - Remap zero: output two follows PWM two; one: PWM one.
`include "dfs_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module dfs_driver_fault_status_regs #(
  parameter [11:0] ULD_FILT_CYC = `DFS_ULD_FILT_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [5:0] reg_addr,
  input wire reg_rd,
  input wire reg_rc,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  input wire supply_fault_latch_select,
  input wire [3:0] sw_on_req,
  input wire [3:0] sw_low_cur,
  input wire supply_uv,
  input wire supply_ov,
  input wire thermal_warn_raw,
  input wire pwm1,
  input wire pwm2,
  output reg [3:0] sw_enable_q,
  output reg out1_pwm_q,
  output reg out2_pwm_q,
  output reg global_underload_q,
  output reg thermal_warning_flag_q
);
  reg [2:0] s_uv_q;
  reg [2:0] s_ov_q;
  reg [2:0] s_tw_q;
  reg [2:0] s_p1_q;
  reg [2:0] s_p2_q;
  reg [2:0] s_lc_q [0:3];
  reg [3:0] per_output_underload_flag_q;
  reg supply_undervoltage_flag_q;
  reg supply_overvoltage_flag_q;
  reg [15:0] cfg_q;
  reg uv_stable_q;
  reg ov_stable_q;
  reg tw_stable_q;
  reg p1_stable_q;
  reg p2_stable_q;
  reg [3:0] lc_stable_q;
  wire [3:0] uld_det;
  wire rc_uld = reg_rc && (reg_addr == `DFS_OFS_ULD);
  wire rc_sup = reg_rc && (reg_addr == `DFS_OFS_SUP);
  wire global_underload_mask = cfg_q[`DFS_BIT_ULDM];
  wire thermal_warning_mask = cfg_q[`DFS_BIT_TWM];
  wire pwm_remap = cfg_q[`DFS_BIT_SWAP];
  wire supply_block;
  // Stable value once second and third stages agree
  function filt;
    input [2:0] s;
    input prev;
    begin
      filt = (s[1] == s[2]) ? s[2] : prev;
    end
  endfunction
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  integer i;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_uv_q <= 3'h0;
      s_ov_q <= 3'h0;
      s_tw_q <= 3'h0;
      s_p1_q <= 3'h0;
      s_p2_q <= 3'h0;
      uv_stable_q <= 1'b0;
      ov_stable_q <= 1'b0;
      tw_stable_q <= 1'b0;
      p1_stable_q <= 1'b0;
      p2_stable_q <= 1'b0;
      lc_stable_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        s_lc_q[i] <= 3'h0;
    end
    else
    begin
      s_uv_q <= {s_uv_q[1:0], supply_uv};
      s_ov_q <= {s_ov_q[1:0], supply_ov};
      s_tw_q <= {s_tw_q[1:0], thermal_warn_raw};
      s_p1_q <= {s_p1_q[1:0], pwm1};
      s_p2_q <= {s_p2_q[1:0], pwm2};
      uv_stable_q <= filt(s_uv_q, uv_stable_q);
      ov_stable_q <= filt(s_ov_q, ov_stable_q);
      tw_stable_q <= filt(s_tw_q, tw_stable_q);
      p1_stable_q <= filt(s_p1_q, p1_stable_q);
      p2_stable_q <= filt(s_p2_q, p2_stable_q);
      for (i = 0; i < 4; i = i + 1)
      begin
        s_lc_q[i] <= {s_lc_q[i][1:0], sw_low_cur[i]};
        lc_stable_q[i] <= filt(s_lc_q[i], lc_stable_q[i]);
      end
    end
  end
  // ----------------------------------------
  // Underload filters
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_uld
      dfs_uld_filter #(
        .CNT_W(12),
        .FILT_CYC(ULD_FILT_CYC)
      ) u_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .out_on(sw_enable_q[g]),
        .low_cur(lc_stable_q[g]),
        .detect_q(uld_det[g])
      );
    end
  endgenerate
  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_output_underload_flag_q <= 4'h0;
      supply_undervoltage_flag_q <= 1'b0;
      supply_overvoltage_flag_q <= 1'b0;
    end
    else
    begin
      // Set wins over clear
      per_output_underload_flag_q <= uld_det |
        (rc_uld ? 4'h0 : per_output_underload_flag_q);
      supply_undervoltage_flag_q <= uv_stable_q |
        (rc_sup ? 1'b0 : supply_undervoltage_flag_q);
      supply_overvoltage_flag_q <= ov_stable_q |
        (rc_sup ? 1'b0 : supply_overvoltage_flag_q);
    end
  end
  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= `DFS_RST_VAL;
    else if (reg_wr && (reg_addr == `DFS_OFS_CFG))
      cfg_q <= reg_wdata & `DFS_CFG_MASK;
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= `DFS_RST_VAL;
    else if (reg_rd || reg_rc)
    begin
      reg_rdata_q <= `DFS_RST_VAL;
      if (reg_addr == `DFS_OFS_ULD)
        reg_rdata_q[`DFS_ULD_MSB:`DFS_ULD_LSB] <=
          per_output_underload_flag_q;
      else if (reg_addr == `DFS_OFS_SUP)
      begin
        reg_rdata_q[`DFS_BIT_UV] <= supply_undervoltage_flag_q;
        reg_rdata_q[`DFS_BIT_OV] <= supply_overvoltage_flag_q;
      end
      else if (reg_addr == `DFS_OFS_CFG)
        reg_rdata_q <= cfg_q;
    end
  end
  // ----------------------------------------
  // Output stage control
  // ----------------------------------------
  assign supply_block = uv_stable_q || ov_stable_q ||
    (supply_fault_latch_select &&
    (supply_undervoltage_flag_q || supply_overvoltage_flag_q));
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_enable_q <= 4'h0;
      out1_pwm_q <= 1'b0;
      out2_pwm_q <= 1'b0;
      global_underload_q <= 1'b0;
      thermal_warning_flag_q <= 1'b0;
    end
    else
    begin
      sw_enable_q <= supply_block ? 4'h0 : sw_on_req;
      out1_pwm_q <= p1_stable_q;
      out2_pwm_q <= pwm_remap ? p1_stable_q : p2_stable_q;
      global_underload_q <= (|per_output_underload_flag_q) &&
        !global_underload_mask;
      thermal_warning_flag_q <= tw_stable_q && !thermal_warning_mask;
    end
  end
endmodule // dfs_driver_fault_status_regs
`default_nettype wire

/* verification/dfs_host.sv */
// Purpose: Host model on the register port
// Assumes: Called just after a clock edge
// Notes: k 0 read, 1 read-and-clear, 2 write
`timescale 1ns/10ps
`default_nettype none
module dfs_host (
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata_q,
  output var logic [5:0] reg_addr,
  output var logic reg_rd,
  output var logic reg_rc,
  output var logic reg_wr,
  output var logic [15:0] reg_wdata
);
  initial {reg_addr, reg_rd, reg_rc, reg_wr, reg_wdata} = '0;
  task acc(input [1:0] k, input [5:0] a, input [15:0] w,
    output [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = w;
    {reg_wr, reg_rc, reg_rd} = 3'b001 << k;
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_rc, reg_rd} = 3'b000;
    reg_wdata = ~w;
    d = reg_rdata_q;
  endtask
endmodule // dfs_host
`default_nettype wire

/* verification/dfs_monitor.sv */
// Purpose: Port checker of the bank
// Assumes: Fault latency of at most eight cycles
// Notes: Bound to the bank top
`timescale 1ns/10ps
`default_nettype none
module dfs_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_rc,
  input wire logic [15:0] reg_rdata_q,
  input wire logic supply_uv,
  input wire logic supply_ov,
  input wire logic [3:0] sw_enable_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic rd = reg_rd | reg_rc;
  sequence s_off;
    ##[1:8] sw_enable_q == 4'h0;
  endsequence
  a_uv_shut_off: assert property (supply_uv |-> s_off)
    else $error("on in undervoltage");
  a_ov_shut_off: assert property (supply_ov |-> s_off)
    else $error("on in overvoltage");
  a_high_bits_zero: assert property (reg_rdata_q[15:10] == 6'h00)
    else $error("high bits set");
  a_uld_bit_layout: assert property (
    rd && reg_addr == 6'h11 |=> reg_rdata_q[5:0] == 6'h00)
    else $error("underload layout");
  a_sup_bit_layout: assert property (
    rd && reg_addr == 6'h12 |=> (reg_rdata_q & 16'hFFF3) == 16'h0000)
    else $error("supply layout");
  a_cfg_bit_layout: assert property (
    reg_rd && reg_addr == 6'h3F |=> (reg_rdata_q & 16'hFFF4) == 16'h0000)
    else $error("config layout");
  a_unmapped_reads_zero: assert property (
    rd && !(reg_addr inside {6'h11, 6'h12, 6'h3F}) |=> reg_rdata_q == 0)
    else $error("unmapped data");
  a_rdata_holds: assert property (!rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
endmodule // dfs_monitor
bind dfs_driver_fault_status_regs dfs_monitor u_dfs_monitor (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rc(reg_rc),
  .reg_rdata_q(reg_rdata_q),
  .supply_uv(supply_uv),
  .supply_ov(supply_ov),
  .sw_enable_q(sw_enable_q)
);
`default_nettype wire

/* verification/dfs_driver_fault_status_regs_tb.sv */
// Purpose: Self-checking bench of the bank
// Assumes: Filter set to eight cycles
// Notes: Expected values built from integers
`timescale 1ns/10ps
`default_nettype none
module dfs_driver_fault_status_regs_tb;
  logic clk_sys, rst_n, latch, uv, ov, tw, p1, p2, o1, o2, gu, twf;
  logic rd, rc, wr;
  logic [3:0] on, lo, en;
  logic [5:0] ad;
  logic [15:0] wd, rq, d;
  int error_cnt, samples_checked, seed, e;
  dfs_driver_fault_status_regs #(.ULD_FILT_CYC(12'h008))
    u_dfs_driver_fault_status_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(ad), .reg_rd(rd), .reg_rc(rc), .reg_wr(wr), .reg_wdata(wd),
    .reg_rdata_q(rq), .supply_fault_latch_select(latch),
    .sw_on_req(on), .sw_low_cur(lo), .supply_uv(uv), .supply_ov(ov),
    .thermal_warn_raw(tw), .pwm1(p1), .pwm2(p2), .sw_enable_q(en),
    .out1_pwm_q(o1), .out2_pwm_q(o2), .global_underload_q(gu),
    .thermal_warning_flag_q(twf));
  dfs_host u_dfs_host (.clk_sys(clk_sys), .reg_rdata_q(rq),
    .reg_addr(ad), .reg_rd(rd), .reg_rc(rc), .reg_wr(wr), .reg_wdata(wd));
  task chk(input [15:0] s, x);
    samples_checked++;
    if (s !== x)
    begin
      error_cnt++;
      $display("unexpected %0t %h vs %h", $time, s, x);
    end
  endtask
  task rr(input [1:0] k, input [5:0] r, input [15:0] x);
    u_dfs_host.acc(k, r, 16'h0000, d);
    chk(d, x);
  endtask
  task w(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #40000;
    error_cnt++;
    summarize;
  end
  initial
  begin
    {rst_n, latch, uv, ov, tw, p1, p2, on, lo} = '0;
    seed = 46721;
    w(10);
    rst_n = 1;
    rr(0, 6'h11, 16'h0000);
    rr(0, 6'h12, 16'h0000);
    rr(0, 6'h20, 16'h0000);
    e = $random(seed);
    u_dfs_host.acc(2, 6'h3F, e[15:0], d);
    rr(0, 6'h3F, e[15:0] & 16'h000B);
    u_dfs_host.acc(2, 6'h11, 16'hFFFF, d);
    rr(1, 6'h11, 16'h0000);
    $display("regs end");
    tw = 1;
    for (int i = 0; i < 4; i++)
    begin
      e = $random(seed);
      {p1, p2} = e[1:0];
      u_dfs_host.acc(2, 6'h3F, {12'h000, i[1], 2'b00, i[0]}, d);
      w(8);
      chk(o1, p1);
      chk(o2, i[0] ? p1 : p2);
      chk(twf, !i[1]);
    end
    $display("config end");
    on = 4'hF;
    u_dfs_host.acc(2, 6'h3F, 16'h0000, d);
    for (int l = 0; l < 2; l++)
    begin
      latch = l[0];
      uv = !l[0];
      ov = l[0];
      w(8);
      chk(en, 16'h0000);
      rr(0, 6'h12, l ? 16'h0004 : 16'h0008);
      {uv, ov} = 2'b00;
      w(8);
      chk(en, l ? 16'h0000 : 16'h000F);
      rr(1, 6'h12, l ? 16'h0004 : 16'h0008);
      rr(0, 6'h12, 16'h0000);
      w(8);
      chk(en, 16'h000F);
    end
    $display("supply end");
    on = 4'h0;
    lo = 4'hF;
    w(20);
    rr(0, 6'h11, 16'h0000);
    on = 4'hF;
    e = $random(seed) | 1;
    lo = e[3:0];
    w(6);
    rr(0, 6'h11, 16'h0000);
    w(12);
    rr(0, 6'h11, {6'h00, e[3:0], 6'h00});
    chk(gu, 16'h0001);
    u_dfs_host.acc(2, 6'h3F, 16'h0002, d);
    w(4);
    chk(gu, 16'h0000);
    rr(1, 6'h11, {6'h00, e[3:0], 6'h00});
    lo = 4'h0;
    w(6);
    rr(1, 6'h11, {6'h00, e[3:0], 6'h00});
    rr(0, 6'h11, 16'h0000);
    $display("underload end");
    summarize;
  end
endmodule // dfs_driver_fault_status_regs_tb
`default_nettype wire
